//--- prescaler_pkg.sv
// shared constants for the timer prescaler and tick source selection
package prescaler_pkg;
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // divider and selection widths
    localparam int DIV_W = 10;
    localparam int SEL_W = 3;
    // number of prescaler taps
    localparam int TAP_N = 4;
    // low divider bits that must all be one for each tap
    localparam int TAP8_BITS = 3;
    localparam int TAP64_BITS = 6;
    localparam int TAP256_BITS = 8;
    localparam int TAP1024_BITS = 10;
    // tap indices
    localparam int TAP_IDX_8 = 0;
    localparam int TAP_IDX_64 = 1;
    localparam int TAP_IDX_256 = 2;
    localparam int TAP_IDX_1024 = 3;
    // tick source encodings, in their register order 0..7
    typedef enum logic [SEL_W-1:0] {
        SEL_OFF, SEL_DIRECT, SEL_DIV8, SEL_DIV64,
        SEL_DIV256, SEL_DIV1024, SEL_PIN_FALL, SEL_PIN_RISE
    } tick_source_e;
    // register offsets
    localparam logic [ADDR_W-1:0] MISC_FUNCTION_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] TIMER_A_CTRL_OFS = 8'h01;
    localparam logic [ADDR_W-1:0] TIMER_B_CTRL_OFS = 8'h02;
    localparam logic [ADDR_W-1:0] TIMER_A_COUNT_OFS = 8'h03;
    localparam logic [ADDR_W-1:0] TIMER_B_COUNT_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] DIV_LOW_OFS = 8'h05;
    localparam logic [ADDR_W-1:0] DIV_HIGH_OFS = 8'h06;
    localparam logic [ADDR_W-1:0] PIN_STATE_OFS = 8'h07;
    // field positions and reset values
    localparam int DIVIDER_RESET_BIT = 0;
    localparam int PIN_A_BIT = 0;
    localparam int PIN_B_BIT = 1;
    localparam logic [DIV_W-1:0] DIV_RESET_VAL = 10'h000;
    localparam logic [DATA_W-1:0] COUNT_RESET_VAL = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
endpackage : prescaler_pkg

//--- pin_count_sync.sv
// count pin synchroniser and edge detector
`timescale 1ns/1ns
`default_nettype none
module pin_count_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic half_q;
    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic agree;

    // half-cycle capture, stands in for the clock-high transparent latch
    always_ff @(negedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 1'b0;
        end else begin
            half_q <= pin;
        end
    end

    // rising-edge stages, then the accepted level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            sync1_q <= half_q;
            sync2_q <= sync1_q;
            if (agree) begin
                level_q <= sync2_q;
            end
        end
    end

    // a change counts once the second and third stages agree
    assign agree = (sync1_q == sync2_q);
    assign level = level_q;
    assign rise = agree & sync2_q & ~level_q;
    assign fall = agree & ~sync2_q & level_q;
endmodule : pin_count_sync
`default_nettype wire

//--- tick_source_mux.sv
// per-timer tick source selection
`timescale 1ns/1ns
`default_nettype none
module tick_source_mux
    import prescaler_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [SEL_W-1:0] source_select,
    input wire logic [TAP_N-1:0] tap_pulse,
    input wire logic pin_rise,
    input wire logic pin_fall,
    output logic tick
);
    logic tick_q;
    logic tick_d;

    // decode of the three-bit source select
    always_comb begin
        case (tick_source_e'(source_select))
            SEL_OFF: tick_d = 1'b0;
            SEL_DIRECT: tick_d = 1'b1;
            SEL_DIV8: tick_d = tap_pulse[TAP_IDX_8];
            SEL_DIV64: tick_d = tap_pulse[TAP_IDX_64];
            SEL_DIV256: tick_d = tap_pulse[TAP_IDX_256];
            SEL_DIV1024: tick_d = tap_pulse[TAP_IDX_1024];
            SEL_PIN_FALL: tick_d = pin_fall;
            SEL_PIN_RISE: tick_d = pin_rise;
            default: tick_d = 1'b0;
        endcase
    end

    // one-cycle tick register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : tick_source_mux
`default_nettype wire

//--- shared_timer_prescaler_clock_select.sv
// shared prescaler, pin sync and tick source select for two timers
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - one divider feeds both timers, each timer selects its own source.
// - select value 1 ticks the timer every system clock cycle.
// - four taps divide the system clock by 8, 64, 256 and 1024.
// - select 0 off, 1 direct, 2-5 taps, 6 pin falling, 7 pin rising.
// - with no source selected no tick is produced.
// - the divider runs freely, untouched by any source selection change.
// - first prescaled tick arrives 1 to N+1 cycles after selection.
// - a divider reset shifts the tap phase for both timers together.
// - writing one resets the divider, hardware then clears the bit.
// - the divider reset bit always reads back as zero.
// - the count pin is sampled each cycle, synchronised, then edge detected.
// - half-cycle capture on clock high, then rising-edge registers.
// - one tick per detected edge, rising for 7, falling for 6.
// - pin edge to tick takes 2.5 to 3.5 system clock cycles.
// - pin edges become ticks directly, without any division.
// - pin edges tick the timer even when the pin is an output.
module shared_timer_prescaler_clock_select
    import prescaler_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic first_count_pin,
    input wire logic second_count_pin,
    output logic timer_a_tick,
    output logic timer_b_tick
);
    logic rst_meta_q;
    logic rst_n_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic [DIV_W-1:0] div_cnt_d;
    logic divider_reset_bit_q;
    logic [SEL_W-1:0] timer_a_source_select_q;
    logic [SEL_W-1:0] timer_b_source_select_q;
    logic [DATA_W-1:0] count_a_q;
    logic [DATA_W-1:0] count_b_q;
    logic [DATA_W-1:0] reg_rdata_q;
    logic [DATA_W-1:0] read_mux;
    logic [TAP_N-1:0] tap_pulse;
    logic pin_a_level;
    logic pin_b_level;
    logic pin_a_rise;
    logic pin_a_fall;
    logic pin_b_rise;
    logic pin_b_fall;
    logic tick_a;
    logic tick_b;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // register decode
    logic wr_misc;
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_count_a;
    logic wr_count_b;
    logic div_rst;
    assign wr_misc = reg_wr && (reg_addr == MISC_FUNCTION_OFS);
    assign wr_ctrl_a = reg_wr && (reg_addr == TIMER_A_CTRL_OFS);
    assign wr_ctrl_b = reg_wr && (reg_addr == TIMER_B_CTRL_OFS);
    assign wr_count_a = reg_wr && (reg_addr == TIMER_A_COUNT_OFS);
    assign wr_count_b = reg_wr && (reg_addr == TIMER_B_COUNT_OFS);
    // write-one reset request, a zero does nothing
    assign div_rst = wr_misc && reg_wdata[DIVIDER_RESET_BIT];

    // free-running divider, only a reset request restarts it
    assign div_cnt_d = div_rst ? DIV_RESET_VAL : div_cnt_q + 1'b1;

    // each tap fires when its low divider bits are all one
    assign tap_pulse[TAP_IDX_8] = &div_cnt_q[TAP8_BITS-1:0];
    assign tap_pulse[TAP_IDX_64] = &div_cnt_q[TAP64_BITS-1:0];
    assign tap_pulse[TAP_IDX_256] = &div_cnt_q[TAP256_BITS-1:0];
    assign tap_pulse[TAP_IDX_1024] = &div_cnt_q[TAP1024_BITS-1:0];

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_cnt_q <= DIV_RESET_VAL;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    // reset bit set by the write, cleared by hardware next cycle
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            divider_reset_bit_q <= 1'b0;
        end else begin
            divider_reset_bit_q <= div_rst;
        end
    end

    // source select registers
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timer_a_source_select_q <= SEL_OFF;
            timer_b_source_select_q <= SEL_OFF;
        end else begin
            if (wr_ctrl_a) begin
                timer_a_source_select_q <= reg_wdata[SEL_W-1:0];
            end
            if (wr_ctrl_b) begin
                timer_b_source_select_q <= reg_wdata[SEL_W-1:0];
            end
        end
    end

    // pin sync, pin is read whatever its direction
    pin_count_sync u_sync_a (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .pin(first_count_pin),
        .level(pin_a_level),
        .rise(pin_a_rise),
        .fall(pin_a_fall)
    );

    pin_count_sync u_sync_b (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .pin(second_count_pin),
        .level(pin_b_level),
        .rise(pin_b_rise),
        .fall(pin_b_fall)
    );

    tick_source_mux u_mux_a (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .source_select(timer_a_source_select_q),
        .tap_pulse(tap_pulse),
        .pin_rise(pin_a_rise),
        .pin_fall(pin_a_fall),
        .tick(tick_a)
    );

    tick_source_mux u_mux_b (
        .core_clk(core_clk),
        .rst_n(rst_n_q),
        .source_select(timer_b_source_select_q),
        .tap_pulse(tap_pulse),
        .pin_rise(pin_b_rise),
        .pin_fall(pin_b_fall),
        .tick(tick_b)
    );

    assign timer_a_tick = tick_a;
    assign timer_b_tick = tick_b;

    // tick counters, a write has priority over a count
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            count_a_q <= COUNT_RESET_VAL;
            count_b_q <= COUNT_RESET_VAL;
        end else begin
            if (wr_count_a) begin
                count_a_q <= reg_wdata;
            end else if (tick_a) begin
                count_a_q <= count_a_q + 1'b1;
            end
            if (wr_count_b) begin
                count_b_q <= reg_wdata;
            end else if (tick_b) begin
                count_b_q <= count_b_q + 1'b1;
            end
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        read_mux = READ_ZERO;
        case (reg_addr)
            // reset bit never reads as one
            MISC_FUNCTION_OFS: read_mux = READ_ZERO;
            TIMER_A_CTRL_OFS: read_mux[SEL_W-1:0] = timer_a_source_select_q;
            TIMER_B_CTRL_OFS: read_mux[SEL_W-1:0] = timer_b_source_select_q;
            TIMER_A_COUNT_OFS: read_mux = count_a_q;
            TIMER_B_COUNT_OFS: read_mux = count_b_q;
            DIV_LOW_OFS: read_mux = div_cnt_q[DATA_W-1:0];
            DIV_HIGH_OFS: read_mux[DIV_W-DATA_W-1:0] = div_cnt_q[DIV_W-1:DATA_W];
            PIN_STATE_OFS: begin
                read_mux[PIN_A_BIT] = pin_a_level;
                read_mux[PIN_B_BIT] = pin_b_level;
            end
            default: read_mux = READ_ZERO;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata_q <= READ_ZERO;
        end else begin
            reg_rdata_q <= reg_rd ? read_mux : READ_ZERO;
        end
    end

    assign reg_rdata = reg_rdata_q;

    // checks on the tick and divider behaviour
    property p_direct_tick;
        @(posedge core_clk) disable iff (!rst_n_q)
        (timer_a_source_select_q == SEL_DIRECT) |=> timer_a_tick;
    endproperty
    a_direct_tick: assert property (p_direct_tick) else $error("direct source missed tick");

    property p_off_idle;
        @(posedge core_clk) disable iff (!rst_n_q)
        (timer_b_source_select_q == SEL_OFF) |=> !timer_b_tick;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("tick with no source");

    property p_div8_tap;
        @(posedge core_clk) disable iff (!rst_n_q)
        (timer_a_source_select_q == SEL_DIV8) |=>
            (timer_a_tick == $past(&div_cnt_q[TAP8_BITS-1:0]));
    endproperty
    a_div8_tap: assert property (p_div8_tap) else $error("divide by 8 tick wrong");

    property p_div_runs;
        @(posedge core_clk) disable iff (!rst_n_q)
        !div_rst |=> (div_cnt_q == $past(div_cnt_q) + 10'h001);
    endproperty
    a_div_runs: assert property (p_div_runs) else $error("divider did not advance");

    property p_div_zero;
        @(posedge core_clk) disable iff (!rst_n_q)
        div_rst |=> (div_cnt_q == DIV_RESET_VAL);
    endproperty
    a_div_zero: assert property (p_div_zero) else $error("divider not zeroed");

    property p_bit_self_clear;
        @(posedge core_clk) disable iff (!rst_n_q)
        div_rst ##1 !div_rst |-> divider_reset_bit_q ##1 !divider_reset_bit_q;
    endproperty
    a_bit_self_clear: assert property (p_bit_self_clear) else $error("reset bit stuck");

    property p_bit_reads_zero;
        @(posedge core_clk) disable iff (!rst_n_q)
        (reg_rd && reg_addr == MISC_FUNCTION_OFS) |=> (reg_rdata[DIVIDER_RESET_BIT] == 1'b0);
    endproperty
    a_bit_reads_zero: assert property (p_bit_reads_zero) else $error("reset bit read one");

    property p_rise_tick;
        @(posedge core_clk) disable iff (!rst_n_q)
        (timer_a_source_select_q == SEL_PIN_RISE) |=> (timer_a_tick == $past(pin_a_rise));
    endproperty
    a_rise_tick: assert property (p_rise_tick) else $error("rising edge tick wrong");

    property p_fall_only;
        @(posedge core_clk) disable iff (!rst_n_q)
        (timer_b_source_select_q == SEL_PIN_FALL) |=> (timer_b_tick == $past(pin_b_fall));
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("falling edge tick wrong");

    property p_first_tick;
        @(posedge core_clk) disable iff (!rst_n_q)
        (timer_a_source_select_q == SEL_DIV64 && !div_rst) |->
            ##[1:65] (timer_a_tick || timer_a_source_select_q != SEL_DIV64 || div_rst);
    endproperty
    a_first_tick: assert property (p_first_tick) else $error("prescaled tick too late");

    property p_shared_phase;
        @(posedge core_clk) disable iff (!rst_n_q)
        (timer_a_source_select_q == SEL_DIV8 && timer_b_source_select_q == SEL_DIV8)
            |=> (timer_a_tick == timer_b_tick);
    endproperty
    a_shared_phase: assert property (p_shared_phase) else $error("timers out of phase");

    // main scenarios
    c_div_reset: cover property (@(posedge core_clk) disable iff (!rst_n_q) div_rst);
    c_div1024: cover property (@(posedge core_clk) disable iff (!rst_n_q)
        timer_b_source_select_q == SEL_DIV1024 && timer_b_tick);
    c_pin_rise: cover property (@(posedge core_clk) disable iff (!rst_n_q)
        timer_a_source_select_q == SEL_PIN_RISE && timer_a_tick);
    c_pin_fall: cover property (@(posedge core_clk) disable iff (!rst_n_q)
        timer_b_source_select_q == SEL_PIN_FALL && timer_b_tick);
endmodule : shared_timer_prescaler_clock_select
`default_nettype wire

//--- count_pin_source.sv
// external clock source model driving both count pins
`timescale 1ns/1ns
`default_nettype none
module count_pin_source (
    input wire logic run,
    output logic pin_a,
    output logic pin_b
);
    // pins sit low and stable until a burst is requested
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // 43 ns phases, unrelated to the core clock
    // each pulse finishes low, so the pin is stable between bursts
    always begin
        wait (run === 1'b1);
        #43 pin_a = 1'b1;
        #43 pin_a = 1'b0;
    end
    // slower second pin, also parks low
    always begin
        wait (run === 1'b1);
        #57 pin_b = 1'b1;
        #57 pin_b = 1'b0;
    end
endmodule : count_pin_source
`default_nettype wire

//--- shared_timer_prescaler_clock_select_test.sv
// register level tests of the shared prescaler and tick source select
`timescale 1ns/1ns
`default_nettype none
module shared_timer_prescaler_clock_select_test;
    import prescaler_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic first_count_pin, second_count_pin, timer_a_tick, timer_b_tick;
    logic [DATA_W-1:0] d, v1;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int ticks_a = 0;
    int ticks_b = 0;
    int edges_a = 0;
    int edges_b = 0;
    int n, na, nb;
    int tap_n [4] = '{8, 64, 256, 1024};
    time rise_a = 0;
    bit ext_on = 1'b0;

    always #5 core_clk = ~core_clk;

    shared_timer_prescaler_clock_select dut (
        .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_count_pin(first_count_pin), .second_count_pin(second_count_pin),
        .timer_a_tick(timer_a_tick), .timer_b_tick(timer_b_tick)
    );
    count_pin_source far_side (.run(run), .pin_a(first_count_pin), .pin_b(second_count_pin));

    // one cycle bus write and read
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] r);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask : rd
    // compares for register bytes and for counts
    task automatic chk8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkn(input int got, input int exp);
        compares++;
        if (got != exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkn
    // cycles until the chosen timer ticks, bounded
    task automatic wait_tick(input bit use_b, input int lim, output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            #1 c++;
        end while ((use_b ? timer_b_tick : timer_a_tick) !== 1'b1 && c < lim);
    endtask : wait_tick
    task automatic test_done;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // tick and pin edge bookkeeping
    always @(posedge core_clk) begin
        #1;
        if (timer_b_tick === 1'b1) ticks_b++;
        if (timer_a_tick === 1'b1) begin
            ticks_a++;
            if (ext_on) chkn(int'($time - rise_a) >= 25 && int'($time - rise_a) <= 36, 1);
        end
    end
    always @(posedge first_count_pin) begin
        rise_a = $time;
        edges_a++;
    end
    always @(negedge second_count_pin) edges_b++;
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        // reset state, unmapped read, idle timers
        rd(TIMER_A_CTRL_OFS, d); chk8(d, 8'h00);
        rd(TIMER_B_CTRL_OFS, d); chk8(d, 8'h00);
        rd(MISC_FUNCTION_OFS, d); chk8(d, READ_ZERO);
        rd(8'h20, d); chk8(d, 8'h00);
        rd(PIN_STATE_OFS, d); chk8(d, 8'h00);
        repeat (1100) @(posedge core_clk);
        chkn(ticks_a, 0);
        chkn(ticks_b, 0);
        $display("test idle done");
        // undivided clock on one timer only
        wr(TIMER_A_CTRL_OFS, 8'h01);
        rd(TIMER_A_CTRL_OFS, d); chk8(d, 8'h01);
        @(posedge core_clk);
        #2 ticks_a = 0;
        ticks_b = 0;
        repeat (16) @(posedge core_clk);
        #2 chkn(ticks_a, 16);
        chkn(ticks_b, 0);
        wr(TIMER_A_CTRL_OFS, 8'h00);
        $display("test direct done");
        // each tap: first tick bound and exact period
        for (int i = 0; i < 4; i++) begin
            wr(TIMER_B_CTRL_OFS, 8'(i + 2));
            wait_tick(1'b1, tap_n[i] + 2, n); chkn(n <= tap_n[i] + 1, 1);
            wait_tick(1'b1, tap_n[i] + 2, n); chkn(n, tap_n[i]);
        end
        wr(TIMER_B_CTRL_OFS, 8'h00);
        $display("test taps done");
        // divider reset realigns both timers
        wr(TIMER_A_CTRL_OFS, 8'h02);
        wr(TIMER_B_CTRL_OFS, 8'h03);
        wr(MISC_FUNCTION_OFS, 8'h01);
        na = 0;
        nb = 0;
        for (n = 1; n <= 90; n++) begin
            @(posedge core_clk);
            #1;
            if (n > 2 && na == 0 && timer_a_tick === 1'b1) na = n;
            if (n > 2 && nb == 0 && timer_b_tick === 1'b1) nb = n;
        end
        chkn(nb - na, 56);
        chkn(na <= 9, 1);
        rd(MISC_FUNCTION_OFS, d); chk8(d, READ_ZERO);
        // free running divider, zero write ignored
        rd(DIV_LOW_OFS, v1);
        wr(TIMER_A_CTRL_OFS, 8'h03);
        wr(TIMER_B_CTRL_OFS, 8'h05);
        wr(MISC_FUNCTION_OFS, 8'h00);
        rd(DIV_LOW_OFS, d); chk8(8'(d - v1), 8'h08);
        $display("test divider done");
        // external pins, selected while pins are stable low
        wr(TIMER_A_CTRL_OFS, 8'h07);
        wr(TIMER_B_CTRL_OFS, 8'h06);
        wr(TIMER_A_COUNT_OFS, 8'h00);
        wr(TIMER_B_COUNT_OFS, 8'h00);
        @(posedge core_clk);
        #2 ticks_a = 0;
        ticks_b = 0;
        edges_a = 0;
        edges_b = 0;
        ext_on = 1'b1;
        @(posedge core_clk);
        run <= 1'b1;
        repeat (100) @(posedge core_clk);
        run <= 1'b0;
        repeat (30) @(posedge core_clk);
        #2 ext_on = 1'b0;
        chkn(edges_a > 5, 1);
        chkn(ticks_a, edges_a);
        chkn(ticks_b, edges_b);
        rd(TIMER_A_COUNT_OFS, d); chk8(d, 8'(edges_a));
        rd(TIMER_B_COUNT_OFS, d); chk8(d, 8'(edges_b));
        rd(PIN_STATE_OFS, d); chk8(d, 8'h00);
        wr(TIMER_A_CTRL_OFS, 8'h00);
        wr(TIMER_B_CTRL_OFS, 8'h00);
        $display("test external done");
        test_done();
    end
endmodule : shared_timer_prescaler_clock_select_test
`default_nettype wire
